// *** hdl/phpm_host_port.v ***
`timescale 1ns/1ns
`include "phpm_defines.vh"
// Parallel host port with pin sharing, APB register access
module phpm_host_port (
   input wire pclk,
   input wire presetn,
   input wire [`PHPM_AW-1:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire host_select_n,
   input wire host_input_strobe,
   input wire host_output_strobe,
   input wire host_byte_select,
   input wire status_select,
   input wire [7:0] host_data_in,
   output reg [7:0] host_data_out,
   output reg [7:0] host_data_oe_n,
   output reg input_buffer_full,
   output reg output_buffer_empty,
   output reg irq,
   input wire [3:0] serial_tx_lines,
   input wire [3:0] serial_tx_oe_n,
   output reg [3:0] serial_rx_lines,
   input wire [7:0] bit_io_tx,
   input wire [7:0] bit_io_oe_n,
   output reg [7:0] bit_io_rx
);

   // Register state
   reg [`PHPM_CFG_W-1:0] cfg_q;
   reg [15:0] in_data_q;
   reg [15:0] out_data_q;
   reg [5:0] usr_q;
   reg ibf_q;
   reg obe_q;
   reg [`PHPM_IRQ_W-1:0] istat_q;
   reg [`PHPM_IRQ_W-1:0] imask_q;

   // Host side state
   reg wr_act_q;
   reg rd_act_q;
   reg [7:0] hold_data_q;
   reg hold_bsel_q;
   reg rd_bsel_q;
   reg rd_ssel_q;

   // Synchronised pins
   wire [`PHPM_SY_W-1:0] sy;
   wire cs_n_s;
   wire ids_s;
   wire ods_s;
   wire bsel_s;
   wire ssel_s;
   wire [7:0] din_s;

   // Configuration decode
   wire serial_sel;
   wire bio_high;
   wire rwds_mode;
   wire ds_high;
   wire flag_or;
   wire host_mode;
   wire full_bio;

   // Strobe decode
   wire ds_act;
   wire wr_act;
   wire rd_act;
   wire cap_evt;
   wire rdn_evt;

   // Bus decode
   wire setup;
   wire access;
   wire wr_en;
   wire rd_done;
   wire [7:0] st_byte;
   wire [7:0] rd_byte;
   wire [`PHPM_IRQ_W-1:0] evt;

   // Next values
   reg [31:0] prdata_d;
   reg pslverr_d;
   reg [7:0] pin_out_d;
   reg [7:0] pin_oe_n_d;
   reg [3:0] ser_rx_d;
   reg [7:0] bio_rx_d;

   // Match of an APB address against a register offset
   function hit;
      input [`PHPM_AW-1:0] a;
      input [`PHPM_AW-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // True for any mapped offset
   function mapped;
      input [`PHPM_AW-1:0] a;
      begin
         mapped = hit(a, `PHPM_A_CFG) | hit(a, `PHPM_A_IN) |
                  hit(a, `PHPM_A_OUT) | hit(a, `PHPM_A_STAT) |
                  hit(a, `PHPM_A_ISTAT) | hit(a, `PHPM_A_IMASK);
      end
   endfunction

   // Host pins cross into the clock domain here
   phpm_sync #(
      .W(`PHPM_SY_W),
      .RST(`PHPM_SY_RST)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({host_data_in, status_select, host_byte_select,
          host_output_strobe, host_input_strobe, host_select_n}),
      .q(sy)
   );

   // Unpack synchronised pins
   assign cs_n_s = sy[`PHPM_SY_CSN];
   assign ids_s = sy[`PHPM_SY_IDS];
   assign ods_s = sy[`PHPM_SY_ODS];
   assign bsel_s = sy[`PHPM_SY_BSEL];
   assign ssel_s = sy[`PHPM_SY_SSEL];
   assign din_s = sy[`PHPM_SY_DHI:`PHPM_SY_DLO];

   // Configuration fields
   assign serial_sel = cfg_q[`PHPM_CFG_SSEL];
   assign bio_high = cfg_q[`PHPM_CFG_BIOH];
   assign rwds_mode = cfg_q[`PHPM_CFG_RWDS];
   assign ds_high = cfg_q[`PHPM_CFG_DSHI];
   assign flag_or = cfg_q[`PHPM_CFG_FOR];
   assign host_mode = ~serial_sel;
   assign full_bio = serial_sel & bio_high;

   // Data strobe active at its programmed level
   assign ds_act = (ods_s == ds_high);

   // Write and read phases, gated by select and port mode
   assign wr_act = host_mode & ~cs_n_s &
                   (rwds_mode ? (ds_act & ~ids_s) : ~ids_s);
   assign rd_act = host_mode & ~cs_n_s &
                   (rwds_mode ? (ds_act & ids_s) : ~ods_s);

   // End of a phase is when strobe or select first goes inactive
   assign cap_evt = wr_act_q & ~wr_act;
   assign rdn_evt = rd_act_q & ~rd_act & ~rd_ssel_q;

   // Track phases and hold the last valid data and byte select
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
         hold_data_q <= 8'h00;
         hold_bsel_q <= 1'b0;
         rd_bsel_q <= 1'b0;
         rd_ssel_q <= 1'b0;
      end else begin
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
         if (wr_act) begin
            hold_data_q <= din_s;
            hold_bsel_q <= bsel_s;
         end
         if (rd_act) begin
            rd_bsel_q <= bsel_s;
            rd_ssel_q <= ssel_s;
         end
      end
   end

   // APB phases: answer with pready in the first access cycle
   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign wr_en = access & pwrite & ~pslverr;
   assign rd_done = access & ~pwrite & hit(paddr, `PHPM_A_IN);

   // Status byte seen by both host and processor
   assign st_byte = {usr_q, obe_q, ibf_q};

   // Byte offered to a host read
   assign rd_byte = ssel_s ? st_byte :
                    (bsel_s ? out_data_q[15:8] : out_data_q[7:0]);

   // Read data, chosen in the setup cycle
   always @* begin
      prdata_d = 32'h0000_0000;
      pslverr_d = ~mapped(paddr);
      if (hit(paddr, `PHPM_A_CFG)) begin
         prdata_d[`PHPM_CFG_W-1:0] = cfg_q;
      end
      if (hit(paddr, `PHPM_A_IN)) begin
         prdata_d[15:0] = in_data_q;
      end
      if (hit(paddr, `PHPM_A_OUT)) begin
         prdata_d[15:0] = out_data_q;
      end
      if (hit(paddr, `PHPM_A_STAT)) begin
         prdata_d[7:0] = st_byte;
      end
      if (hit(paddr, `PHPM_A_ISTAT)) begin
         prdata_d[`PHPM_IRQ_W-1:0] = istat_q;
      end
      if (hit(paddr, `PHPM_A_IMASK)) begin
         prdata_d[`PHPM_IRQ_W-1:0] = imask_q;
      end
   end

   // APB answer registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= prdata_d;
            pslverr <= pslverr_d;
         end else if (!psel) begin
            pslverr <= 1'b0;
         end
      end
   end

   // Software registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= `PHPM_CFG_RST;
         out_data_q <= `PHPM_D16_RST;
         usr_q <= `PHPM_USR_RST;
         imask_q <= `PHPM_IRQ_RST;
      end else if (wr_en) begin
         if (hit(paddr, `PHPM_A_CFG)) begin
            cfg_q <= pwdata[`PHPM_CFG_W-1:0];
         end
         if (hit(paddr, `PHPM_A_OUT)) begin
            out_data_q <= pwdata[15:0];
         end
         if (hit(paddr, `PHPM_A_STAT)) begin
            usr_q <= pwdata[7:2];
         end
         if (hit(paddr, `PHPM_A_IMASK)) begin
            imask_q <= pwdata[`PHPM_IRQ_W-1:0];
         end
      end
   end

   // Host writes land in the chosen byte of the input register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_data_q <= `PHPM_D16_RST;
      end else if (cap_evt) begin
         if (hold_bsel_q) begin
            in_data_q[15:8] <= hold_data_q;
         end else begin
            in_data_q[7:0] <= hold_data_q;
         end
      end
   end

   // Buffer flags; a host event beats a processor clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ibf_q <= 1'b0;
         obe_q <= 1'b1;
      end else begin
         if (cap_evt) begin
            ibf_q <= 1'b1;
         end else if (rd_done) begin
            ibf_q <= 1'b0;
         end
         if (rdn_evt) begin
            obe_q <= 1'b1;
         end else if (wr_en && hit(paddr, `PHPM_A_OUT)) begin
            obe_q <= 1'b0;
         end
      end
   end

   // Interrupt events
   assign evt = {rdn_evt, cap_evt};

   // Sticky status, write one to clear, set wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_q <= `PHPM_IRQ_RST;
      end else if (wr_en && hit(paddr, `PHPM_A_ISTAT)) begin
         istat_q <= (istat_q & ~pwdata[`PHPM_IRQ_W-1:0]) | evt;
      end else begin
         istat_q <= istat_q | evt;
      end
   end

   // Shared pin routing by port mode
   always @* begin
      pin_out_d = 8'h00;
      pin_oe_n_d = 8'hFF;
      ser_rx_d = 4'h0;
      bio_rx_d = 8'h00;
      if (host_mode) begin
         if (rd_act) begin
            pin_out_d = rd_byte;
            pin_oe_n_d = 8'h00;
         end
      end else if (full_bio) begin
         pin_out_d = bit_io_tx;
         pin_oe_n_d = bit_io_oe_n;
         bio_rx_d = din_s;
      end else begin
         pin_out_d = {bit_io_tx[3:0], serial_tx_lines};
         pin_oe_n_d = {bit_io_oe_n[3:0], serial_tx_oe_n};
         ser_rx_d = din_s[3:0];
         bio_rx_d = {4'h0, din_s[7:4]};
      end
   end

   // Registered pin drive, flags and interrupt
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_data_out <= 8'h00;
         host_data_oe_n <= 8'hFF;
         serial_rx_lines <= 4'h0;
         bit_io_rx <= 8'h00;
         input_buffer_full <= 1'b0;
         output_buffer_empty <= 1'b1;
         irq <= 1'b0;
      end else begin
         host_data_out <= pin_out_d;
         host_data_oe_n <= pin_oe_n_d;
         serial_rx_lines <= ser_rx_d;
         bit_io_rx <= bio_rx_d;
         input_buffer_full <= flag_or ? (ibf_q | obe_q) : ibf_q;
         output_buffer_empty <= obe_q;
         irq <= |(istat_q & imask_q);
      end
   end

endmodule // phpm_host_port

// *** hdl/phpm_sync.v ***
`timescale 1ns/1ns
// Two-stage synchroniser, one pair of flops per bit
module phpm_sync #(
   parameter W = 1,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         // First stage feeds only the second
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_q <= RST[i];
               sync_q <= RST[i];
            end else begin
               meta_q <= d[i];
               sync_q <= meta_q;
            end
         end
         assign q[i] = sync_q;
      end
   endgenerate
endmodule // phpm_sync

// *** inc/phpm_defines.vh ***
`ifndef PHPM_DEFINES_VH
`define PHPM_DEFINES_VH
// APB register byte offsets
`define PHPM_AW 8
`define PHPM_A_CFG 8'h00
`define PHPM_A_IN 8'h04
`define PHPM_A_OUT 8'h08
`define PHPM_A_STAT 8'h0C
`define PHPM_A_ISTAT 8'h10
`define PHPM_A_IMASK 8'h14
// Configuration register fields
`define PHPM_CFG_W 5
`define PHPM_CFG_RST 5'h00
`define PHPM_CFG_SSEL 0
`define PHPM_CFG_BIOH 1
`define PHPM_CFG_RWDS 2
`define PHPM_CFG_DSHI 3
`define PHPM_CFG_FOR 4
// Host status byte fields
`define PHPM_ST_IBF 0
`define PHPM_ST_OBE 1
`define PHPM_USR_RST 6'h00
// Interrupt status bits
`define PHPM_IRQ_W 2
`define PHPM_IRQ_CAP 0
`define PHPM_IRQ_RDN 1
`define PHPM_IRQ_RST 2'h0
// Synchronised pin vector layout
`define PHPM_SY_W 13
`define PHPM_SY_RST 13'h0007
`define PHPM_SY_CSN 0
`define PHPM_SY_IDS 1
`define PHPM_SY_ODS 2
`define PHPM_SY_BSEL 3
`define PHPM_SY_SSEL 4
`define PHPM_SY_DLO 5
`define PHPM_SY_DHI 12
`define PHPM_D16_RST 16'h0000
`endif

// *** verif/phpm_host_model.sv ***
`timescale 1ns/1ns
// External host processor on the 8-bit bus
module phpm_host_model (
   input wire pclk,
   input wire strobe_mode,
   input wire ds_high,
   input wire [7:0] dut_out,
   input wire [7:0] dut_oe_n,
   output logic host_select_n,
   output logic host_input_strobe,
   output logic host_output_strobe,
   output logic host_byte_select,
   output logic status_select,
   output wire [7:0] host_data_in
);
   logic [7:0] drv_q = 8'h00;
   logic drv_en_q = 1'b0;
   logic [7:0] last_q = 8'h00;
   // Device drive wins, then host drive, else a float that keeps changing
   assign host_data_in = (~dut_oe_n & dut_out) | (dut_oe_n & (drv_en_q ? drv_q : ~last_q));
   always @(posedge pclk) last_q <= host_data_in;
   initial begin
      host_select_n = 1'b1;
      host_input_strobe = 1'b1;
      host_output_strobe = 1'b1;
      host_byte_select = 1'b0;
      status_select = 1'b0;
   end
   // Inactive strobe levels of the current protocol
   task idle();
      host_select_n <= 1'b1;
      host_input_strobe <= 1'b1;
      host_output_strobe <= strobe_mode ? ~ds_high : 1'b1;
   endtask
   // Park a value on the bus, or release it
   task park(input logic en, input logic [7:0] d);
      drv_q <= d;
      drv_en_q <= en;
   endtask
   // One host access; pulses are held well over three clocks
   task xfer(input logic rd, input logic cs, input logic bsel, input logic stat,
      input logic [7:0] d, output logic [7:0] q);
      host_select_n <= ~cs;
      host_byte_select <= bsel;
      status_select <= stat;
      drv_q <= d;
      drv_en_q <= ~rd;
      host_input_strobe <= rd;
      host_output_strobe <= strobe_mode ? ds_high : ~rd;
      repeat (6) @(posedge pclk);
      q = host_data_in;
      idle();
      repeat (4) @(posedge pclk);
      drv_en_q <= 1'b0;
      @(posedge pclk);
   endtask
endmodule // phpm_host_model

// *** verif/phpm_host_port_monitor.sv ***
`timescale 1ns/1ns
`include "phpm_defines.vh"
// Port-level checks of the host port and its flags
module phpm_host_port_monitor (
   input wire pclk,
   input wire presetn,
   input wire [`PHPM_AW-1:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready,
   input wire host_select_n,
   input wire [7:0] host_data_oe_n,
   input wire input_buffer_full,
   input wire output_buffer_empty,
   input wire [3:0] serial_tx_oe_n,
   input wire [7:0] bit_io_oe_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // No other source drives the shared pins
   wire quiet = (serial_tx_oe_n == 4'hF) && (bit_io_oe_n == 8'hFF);
   wire done = psel && penable && pready;
   chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready is not a single cycle after setup");
   chk_drive_idle: assert property ((host_select_n && quiet)[*5] |-> host_data_oe_n == 8'hFF)
      else $error("host bus driven while host is deselected");
   chk_drive_whole: assert property (quiet[*3] ##0 host_data_oe_n != 8'hFF |-> host_data_oe_n == 8'h00)
      else $error("host bus driven on part of its lines");
   chk_flags_stable: assert property ((host_select_n && !psel)[*8] |->
      $stable(input_buffer_full) && $stable(output_buffer_empty))
      else $error("flag moved with no host or processor access");
   chk_ibf_holds: assert property (input_buffer_full && !psel && !$past(psel) |=> input_buffer_full)
      else $error("input full dropped without a processor access");
   chk_obe_holds: assert property (output_buffer_empty && !psel && !$past(psel) |=> output_buffer_empty)
      else $error("output empty dropped without a processor write");
   chk_ibf_clear: assert property ((host_select_n && !output_buffer_empty)[*5] ##0
      (done && !pwrite && paddr == `PHPM_A_IN) |-> ##[1:2] !input_buffer_full)
      else $error("input full not cleared by input data read");
   chk_obe_clear: assert property (host_select_n[*5] ##0 (done && pwrite && paddr == `PHPM_A_OUT)
      |-> ##[1:2] !output_buffer_empty)
      else $error("output empty not cleared by output data write");
   // Main scenarios reached
   cover property ($rose(input_buffer_full));
   cover property ($rose(output_buffer_empty));
   cover property (host_data_oe_n == 8'h00);
endmodule // phpm_host_port_monitor

bind phpm_host_port phpm_host_port_monitor u_mon (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .host_select_n(host_select_n),
   .host_data_oe_n(host_data_oe_n), .input_buffer_full(input_buffer_full),
   .output_buffer_empty(output_buffer_empty), .serial_tx_oe_n(serial_tx_oe_n),
   .bit_io_oe_n(bit_io_oe_n));

// *** verif/tb_phpm_host_port.sv ***
`timescale 1ns/1ns
`include "phpm_defines.vh"
// Register and host-pin tests of the parallel host port
module tb_phpm_host_port;
   logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
   logic [`PHPM_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic hsn, his, hos, hbs, hss, ibf, obe, irq, err_q, strobe_mode, ds_high;
   logic [7:0] hdi, hdo, hoe_n, bit_io_tx, bit_io_oe_n, bit_io_rx, hb;
   logic [3:0] serial_tx_lines, serial_tx_oe_n, serial_rx_lines;
   integer err_total = 0, num_checks = 0, m;
   always #5 pclk = ~pclk;
   phpm_host_port u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .host_select_n(hsn), .host_input_strobe(his), .host_output_strobe(hos),
      .host_byte_select(hbs), .status_select(hss), .host_data_in(hdi), .host_data_out(hdo),
      .host_data_oe_n(hoe_n), .input_buffer_full(ibf), .output_buffer_empty(obe), .irq(irq),
      .serial_tx_lines(serial_tx_lines), .serial_tx_oe_n(serial_tx_oe_n),
      .serial_rx_lines(serial_rx_lines), .bit_io_tx(bit_io_tx), .bit_io_oe_n(bit_io_oe_n),
      .bit_io_rx(bit_io_rx));
   phpm_host_model u_host (.pclk(pclk), .strobe_mode(strobe_mode), .ds_high(ds_high),
      .dut_out(hdo), .dut_oe_n(hoe_n), .host_select_n(hsn), .host_input_strobe(his),
      .host_output_strobe(hos), .host_byte_select(hbs), .status_select(hss), .host_data_in(hdi));
   // Verdict and end of run
   task test_done();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         err_total++;
      end
   endtask
   // One APB transfer; waits for pready under a bound
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      integer n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         err_total++;
         test_done();
      end else begin
         // Idle edge so the next call never retouches psel in this time step
         @(posedge pclk);
      end
   endtask
   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      serial_tx_lines = 4'h0; serial_tx_oe_n = 4'hF; bit_io_tx = 8'h00; bit_io_oe_n = 8'hFF;
      strobe_mode = 0; ds_high = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      check(ibf, 1'h0);
      check(obe, 1'h1);
      check(hoe_n, 8'hFF);
      apb(0, `PHPM_A_STAT, 32'h0000_0000);
      check(rd_q, 32'h0000_0002);
      apb(0, 8'h18, 32'h0000_0000);
      check(err_q, 1'h1);
      check(rd_q, 32'h0000_0000);
      apb(1, `PHPM_A_IMASK, 32'h0000_0003);
      // Two bytes from the host, separate strobes
      u_host.xfer(0, 1, 0, 0, 8'hA5, hb);
      u_host.xfer(0, 1, 1, 0, 8'h3C, hb);
      repeat (2) @(posedge pclk);
      check({ibf, irq}, 2'h3);
      apb(1, `PHPM_A_IMASK, 32'h0000_0000);
      @(posedge pclk);
      check(irq, 1'h0);
      apb(1, `PHPM_A_IMASK, 32'h0000_0003);
      apb(0, `PHPM_A_IN, 32'h0000_0000);
      check(rd_q, 32'h0000_3CA5);
      apb(1, `PHPM_A_ISTAT, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      check({ibf, irq}, 2'h0);
      u_host.xfer(0, 0, 0, 0, 8'h77, hb);
      repeat (2) @(posedge pclk);
      check(ibf, 1'h0);
      // Host reads: status byte, then output data
      apb(1, `PHPM_A_STAT, 32'h0000_00FC);
      apb(1, `PHPM_A_OUT, 32'h0000_1234);
      repeat (2) @(posedge pclk);
      check(obe, 1'h0);
      u_host.xfer(1, 1, 0, 1, 8'h00, hb);
      check({hb, obe}, 9'h1F8);
      u_host.xfer(1, 1, 1, 0, 8'h00, hb);
      repeat (2) @(posedge pclk);
      check({hb, obe, irq}, 10'h04B);
      apb(0, `PHPM_A_ISTAT, 32'h0000_0000);
      check(rd_q, 32'h0000_0002);
      apb(1, `PHPM_A_ISTAT, 32'h0000_0002);
      apb(1, `PHPM_A_CFG, 32'h0000_0010);
      repeat (2) @(posedge pclk);
      check(ibf, 1'h1);
      apb(1, `PHPM_A_OUT, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      check(ibf, 1'h0);
      // Read/write select with data strobe of either level
      for (m = 0; m < 2; m++) begin
         ds_high <= m[0];
         strobe_mode <= 1'b1;
         apb(1, `PHPM_A_CFG, {28'h000_0000, m[0], 3'h4});
         u_host.idle();
         repeat (4) @(posedge pclk);
         u_host.xfer(0, 1, m[0], 0, 8'h5A, hb);
         repeat (2) @(posedge pclk);
         check(ibf, 1'h1);
         apb(0, `PHPM_A_IN, 32'h0000_0000);
         check(m ? rd_q[15:8] : rd_q[7:0], 8'h5A);
         apb(1, `PHPM_A_OUT, 32'h0000_00C3);
         u_host.xfer(1, 1, 0, 0, 8'h00, hb);
         check(hb, 8'hC3);
      end
      // Pin sharing with the serial port and bit-I/O unit
      strobe_mode <= 1'b0;
      apb(1, `PHPM_A_CFG, 32'h0000_0001);
      u_host.idle();
      u_host.park(1, 8'h96);
      repeat (5) @(posedge pclk);
      check({bit_io_rx[3:0], serial_rx_lines}, 8'h96);
      serial_tx_lines <= 4'hA;
      serial_tx_oe_n <= 4'h0;
      repeat (4) @(posedge pclk);
      check({hoe_n, hdo[3:0]}, 12'hF0A);
      serial_tx_oe_n <= 4'hF;
      apb(1, `PHPM_A_CFG, 32'h0000_0003);
      repeat (5) @(posedge pclk);
      check(bit_io_rx, 8'h96);
      u_host.park(0, 8'h00);
      bit_io_tx <= 8'h5A;
      bit_io_oe_n <= 8'h00;
      repeat (4) @(posedge pclk);
      check({hoe_n, hdo}, 16'h005A);
      test_done();
   end
endmodule // tb_phpm_host_port
